// [board_power_good_reset_control.sv]
// Board power-good sequencing and reset generation with a Wishbone register port.
`timescale 1ns/100ps
`default_nettype none

module board_power_good_reset_control (
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic [3:0] adr_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  input wire logic we_i,
  input wire logic [3:0] sel_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  output logic ack_o,
  // Inputs from pins
  input wire logic system_power_ok_i,
  input wire logic io_side_3v3_request_i,
  input wire logic pod_output_request_i,
  input wire logic system_reset_request_n_i,
  input wire logic bus_error_restart_n_i,
  input wire logic io_event_restart_i,
  input wire logic [3:0] legacy_irq_i,
  input wire logic test_reset_jumper_n_i,
  input wire logic mem_primary_present_n_i,
  input wire logic mem_secondary_present_n_i,
  input wire logic mem_primary_1v25_good_i,
  input wire logic mem_secondary_1v25_good_i,
  input wire logic conv_3v3_present_n_i,
  input wire logic conv_2v5_primary_present_n_i,
  input wire logic conv_2v5_secondary_present_n_i,
  input wire logic rail_3v3_good_i,
  input wire logic rail_2v5_primary_good_i,
  input wire logic rail_2v5_secondary_good_i,
  input wire logic rail_1v5_good_i,
  input wire logic rail_1v2_good_i,
  input wire logic rail_1v8_good_i,
  input wire logic rail_1v3_good_i,
  input wire logic [3:0] cpu_installed_n_i,
  input wire logic [3:0] cpu_pod_good_i,
  // Outputs
  output pwr_reset_pkg::rail_enables_t rail_enables_o,
  output logic [3:0] pod_enable_o,
  output logic board_clocks_enable_o,
  output logic board_power_ok_o,
  output logic any_pod_good_out_o,
  output logic cpu_present_n_o,
  output logic cpu_present_n_oe_o,
  output pwr_reset_pkg::reset_outs_t resets_o,
  output logic [3:0] legacy_irq_o,
  output logic scalability_port_enable_o,
  output logic test_reset_n_o
);

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  localparam int n_in = 33;
  logic [n_in-1:0] raw_in;
  logic [n_in-1:0] sync_a;
  logic [n_in-1:0] sync_b;

  assign raw_in = {system_power_ok_i, io_side_3v3_request_i, pod_output_request_i,
                   system_reset_request_n_i, bus_error_restart_n_i, io_event_restart_i,
                   legacy_irq_i, test_reset_jumper_n_i, mem_primary_present_n_i,
                   mem_secondary_present_n_i, mem_primary_1v25_good_i,
                   mem_secondary_1v25_good_i, conv_3v3_present_n_i,
                   conv_2v5_primary_present_n_i, conv_2v5_secondary_present_n_i,
                   rail_3v3_good_i, rail_2v5_primary_good_i, rail_2v5_secondary_good_i,
                   rail_1v5_good_i, rail_1v2_good_i, rail_1v8_good_i, rail_1v3_good_i,
                   cpu_installed_n_i, cpu_pod_good_i};

  // The synchronisers stay out of reset: they fill with the pin levels while reset is
  // held, so an active-low pin never looks asserted in the cycles after release.
  always_ff @(posedge clk_i) begin
    sync_a <= raw_in;
    sync_b <= sync_a;
  end

  logic sys_pok, req_3v3, pod_req, sys_rst_n, berr_n, io_evt, trst_jmp_n;
  logic [3:0] irq_s;
  logic mem_p_n, mem_s_n, mem_p_ok, mem_s_ok, c33_n, c25p_n, c25s_n;
  logic g33, g25p, g25s, g15, g12, g18, g13;
  logic [3:0] cpu_in_n, pod_gd;

  assign {sys_pok, req_3v3, pod_req, sys_rst_n, berr_n, io_evt, irq_s, trst_jmp_n,
          mem_p_n, mem_s_n, mem_p_ok, mem_s_ok, c33_n, c25p_n, c25s_n,
          g33, g25p, g25s, g15, g12, g18, g13, cpu_in_n, pod_gd} = sync_b;

  // ----------------------------------------------------------------
  // Derived power conditions
  // ----------------------------------------------------------------
  logic [3:0] installed;
  logic mem_both, conv_25_both, g25, pods_ok, all_good;

  assign installed = ~cpu_in_n;
  assign mem_both = ~mem_p_n & ~mem_s_n;
  assign conv_25_both = ~c25p_n & ~c25s_n;
  assign g25 = g25p & g25s;
  assign pods_ok = ((pod_gd & installed) == installed) & (|installed);
  assign all_good = g33 & ~c33_n & g15 & g12 & g18 & g13 & g25 & mem_p_ok & mem_s_ok
                    & pods_ok;

  // ----------------------------------------------------------------
  // Power sequencer
  // ----------------------------------------------------------------
  pwr_reset_pkg::seq_state_t state, next_state;

  // Each state checks only the condition of its own stage, and losing that condition
  // steps the state back; the enables are gated by the memory presence, both requests, the 2.5 V converter presence
  // and the 3.3, 1.5, 1.2 and 1.8 V goods, so enables above those fall in the same cycle.
  always_comb begin
    next_state = state;
    case (state)
      pwr_reset_pkg::seq_off: begin
        if (mem_both && req_3v3 && !c33_n) begin
          next_state = pwr_reset_pkg::seq_3v3;
        end
      end
      pwr_reset_pkg::seq_3v3: begin
        if (!(mem_both && req_3v3 && !c33_n)) begin
          next_state = pwr_reset_pkg::seq_off;
        end else if (g33) begin
          next_state = pwr_reset_pkg::seq_1v5;
        end
      end
      pwr_reset_pkg::seq_1v5: begin
        if (!g33) begin
          next_state = pwr_reset_pkg::seq_3v3;
        end else if (g15) begin
          next_state = pwr_reset_pkg::seq_mid;
        end
      end
      pwr_reset_pkg::seq_mid: begin
        if (!g15) begin
          next_state = pwr_reset_pkg::seq_1v5;
        end else if (g12 && pod_req) begin
          next_state = pwr_reset_pkg::seq_pods;
        end
      end
      pwr_reset_pkg::seq_pods: begin
        if (!g12 || !pod_req) begin
          next_state = pwr_reset_pkg::seq_mid;
        end else if (all_good) begin
          next_state = pwr_reset_pkg::seq_up;
        end
      end
      pwr_reset_pkg::seq_up: begin
        if (!all_good) begin
          next_state = pwr_reset_pkg::seq_pods;
        end
      end
      default: next_state = pwr_reset_pkg::seq_off;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= pwr_reset_pkg::seq_off;
    end else begin
      state <= next_state;
    end
  end

  // Enable outputs decoded from the state and the good inputs.
  pwr_reset_pkg::rail_enables_t next_en;
  logic [3:0] next_pod_en;
  logic next_clk_en, next_pok;

  always_comb begin
    next_en = '0;
    next_en.rail_3v3 = (state != pwr_reset_pkg::seq_off) && mem_both && req_3v3;
    next_en.rail_1v5 = next_en.rail_3v3 && g33 && (state >= pwr_reset_pkg::seq_1v5);
    next_en.rail_1v2 = next_en.rail_1v5 && g15 && (state >= pwr_reset_pkg::seq_mid);
    next_en.rail_1v8 = next_en.rail_1v2;
    next_en.rail_1v3 = next_en.rail_1v2;
    next_en.rail_2v5 = next_en.rail_1v8 && g18 && g33 && conv_25_both;
    next_pod_en = (next_en.rail_1v2 && g12 && pod_req &&
                   (state >= pwr_reset_pkg::seq_pods)) ? installed : 4'h0;
    // Power ok never outlives an enable, so it falls no later than the first rail.
    next_pok = (state == pwr_reset_pkg::seq_up) && all_good && (&next_en);
    next_clk_en = next_pok;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rail_enables_o <= '0;
      pod_enable_o <= 4'h0;
      board_power_ok_o <= 1'b0;
      board_clocks_enable_o <= 1'b0;
      any_pod_good_out_o <= 1'b0;
      cpu_present_n_o <= 1'b1;
      cpu_present_n_oe_o <= 1'b0;
    end else begin
      rail_enables_o <= next_en;
      pod_enable_o <= next_pod_en;
      board_power_ok_o <= next_pok;
      board_clocks_enable_o <= next_clk_en;
      any_pod_good_out_o <= |(pod_gd & installed);
      cpu_present_n_o <= 1'b0;
      cpu_present_n_oe_o <= |installed;
    end
  end

  // ----------------------------------------------------------------
  // Register port
  // ----------------------------------------------------------------
  logic [31:0] ctrl, next_ctrl;
  logic next_ack;
  logic [31:0] next_dat;
  logic wr_ctrl;

  assign wr_ctrl = cyc_i && stb_i && we_i && !ack_o && (adr_i == pwr_reset_pkg::ctrl_addr);

  // Command bits are one-shot: they self-clear after one cycle so a write acts once;
  // the scalability port enable is a level.
  always_comb begin
    next_ctrl = ctrl;
    next_ctrl[pwr_reset_pkg::save_config_pos] = 1'b0;
    next_ctrl[pwr_reset_pkg::save_memory_pos] = 1'b0;
    next_ctrl[pwr_reset_pkg::ctrl_reset_pos] = 1'b0;
    next_ctrl[pwr_reset_pkg::local_hard_reset_pos] = 1'b0;
    next_ctrl[pwr_reset_pkg::soft_restart_pos] = 1'b0;
    if (wr_ctrl) begin
      for (int b = 0; b < 4; b++) begin
        if (sel_i[b]) begin
          next_ctrl[b*8 +: 8] = dat_i[b*8 +: 8];
        end
      end
    end
    next_ctrl[31:9] = '0;
    next_ctrl[7:5] = '0;
    next_ack = cyc_i && stb_i && !ack_o;
    case (adr_i)
      pwr_reset_pkg::ctrl_addr: next_dat = ctrl;
      pwr_reset_pkg::status_addr: next_dat = {24'h0, board_clocks_enable_o, board_power_ok_o,
                                              resets_o[5:4], 3'(state), pod_enable_o[0]};
      pwr_reset_pkg::inputs_addr: next_dat = {20'h0, installed, pod_gd, g33, g25, g15, g12};
      default: next_dat = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl <= pwr_reset_pkg::ctrl_reset_value;
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end else begin
      ctrl <= next_ctrl;
      ack_o <= next_ack;
      dat_o <= next_dat;
    end
  end

  // ----------------------------------------------------------------
  // Reset generation
  // ----------------------------------------------------------------
  logic pok_d, next_pok_d;
  logic [7:0] pgr_cnt, next_pgr_cnt;
  logic cmd_cpu_only;
  pwr_reset_pkg::reset_outs_t next_rst;

  assign cmd_cpu_only = ctrl[pwr_reset_pkg::save_config_pos] &&
                        ctrl[pwr_reset_pkg::save_memory_pos] &&
                        ctrl[pwr_reset_pkg::ctrl_reset_pos];

  // Power-good reset is stretched to a fixed pulse so every consumer sees it.
  always_comb begin
    next_pok_d = sys_pok;
    next_pgr_cnt = pgr_cnt;
    if (sys_pok && !pok_d) begin
      next_pgr_cnt = 8'(pwr_reset_pkg::reset_pulse_cycles);
    end else if (pgr_cnt != 8'h00) begin
      next_pgr_cnt = pgr_cnt - 8'h01;
    end
    next_rst.power_good_reset = (next_pgr_cnt != 8'h00) || !sys_pok;
    next_rst.hard_reset = !sys_rst_n;
    next_rst.cpu_reset = next_rst.power_good_reset || !sys_rst_n
                         || cmd_cpu_only
                         || ctrl[pwr_reset_pkg::local_hard_reset_pos];
    next_rst.local_reset = ctrl[pwr_reset_pkg::local_hard_reset_pos];
    next_rst.ctrl_reset = next_rst.power_good_reset || !sys_rst_n || !berr_n;
    next_rst.restart = ctrl[pwr_reset_pkg::soft_restart_pos] || io_evt;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pok_d <= 1'b0;
      pgr_cnt <= 8'h00;
      resets_o <= '1;
      legacy_irq_o <= 4'h0;
      scalability_port_enable_o <= 1'b0;
      test_reset_n_o <= 1'b0;
    end else begin
      pok_d <= next_pok_d;
      pgr_cnt <= next_pgr_cnt;
      resets_o <= next_rst;
      legacy_irq_o <= irq_s;
      scalability_port_enable_o <= ctrl[pwr_reset_pkg::scal_port_en_pos]
                                   && board_power_ok_o;
      test_reset_n_o <= trst_jmp_n && !next_rst.power_good_reset;
    end
  end

endmodule // board_power_good_reset_control

`default_nettype wire

// [pwr_reset_pkg.sv]
// Shared constants, register map and carrier types for the board power and reset control.
package pwr_reset_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [3:0] ctrl_addr = 4'h0;
  localparam logic [3:0] status_addr = 4'h4;
  localparam logic [3:0] inputs_addr = 4'h8;

  // ----------------------------------------------------------------
  // Control register fields (system_reset_register)
  // ----------------------------------------------------------------
  localparam int save_config_pos = 0;
  localparam int save_memory_pos = 1;
  localparam int ctrl_reset_pos = 2;
  localparam int local_hard_reset_pos = 3;
  localparam int soft_restart_pos = 4;
  localparam int scal_port_en_pos = 8;
  localparam logic [31:0] ctrl_reset_value = 32'h0000_0100;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int clk_mhz = 40;
  localparam int reset_pulse_ns = 1000;
  localparam int reset_pulse_cycles = (reset_pulse_ns * clk_mhz + 999) / 1000;

  // ----------------------------------------------------------------
  // Power sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    seq_off = 3'b000,
    seq_3v3 = 3'b001,
    seq_1v5 = 3'b010,
    seq_mid = 3'b011,
    seq_pods = 3'b100,
    seq_up = 3'b101
  } seq_state_t;

  // Rail enables grouped as one carrier.
  typedef struct packed {
    logic rail_3v3;
    logic rail_1v5;
    logic rail_1v2;
    logic rail_1v8;
    logic rail_1v3;
    logic rail_2v5;
  } rail_enables_t;

  // Reset outputs grouped as one carrier.
  typedef struct packed {
    logic power_good_reset;
    logic hard_reset;
    logic cpu_reset;
    logic local_reset;
    logic ctrl_reset;
    logic restart;
  } reset_outs_t;

endpackage

// [board_power_good_reset_control_props.sv]
// Port checker for the board power-good and reset control block.
`timescale 1ns/100ps
`default_nettype none
module board_power_good_reset_control_props (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic ack_o,
  input wire logic system_power_ok_i,
  input wire logic system_reset_request_n_i,
  input wire logic conv_2v5_primary_present_n_i,
  input wire logic conv_2v5_secondary_present_n_i,
  input wire logic [3:0] cpu_installed_n_i,
  input wire logic [3:0] cpu_pod_good_i,
  input wire pwr_reset_pkg::rail_enables_t rail_enables_o,
  input wire logic [3:0] pod_enable_o,
  input wire logic board_clocks_enable_o,
  input wire logic board_power_ok_o,
  input wire logic any_pod_good_out_o,
  input wire logic cpu_present_n_oe_o,
  input wire pwr_reset_pkg::reset_outs_t resets_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ----------------------------------------------------------------
  // Cycles since system power ok rose, saturating
  // ----------------------------------------------------------------
  logic [6:0] ok_cnt;
  logic [6:0] next_ok_cnt;
  always_comb begin
    next_ok_cnt = ok_cnt;
    if (!system_power_ok_i) begin
      next_ok_cnt = 7'h00;
    end else if (ok_cnt != 7'h7F) begin
      next_ok_cnt = ok_cnt + 7'h01;
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ok_cnt <= 7'h00;
    end else begin
      ok_cnt <= next_ok_cnt;
    end
  end
  chk_ack_latency: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("bus request not acknowledged next cycle");
  chk_ack_pulse: assert property (ack_o |=> !ack_o)
    else $error("acknowledge longer than one cycle");
  chk_clk_follows_ok: assert property (board_clocks_enable_o == board_power_ok_o)
    else $error("clock enable differs from board power ok");
  chk_present_drive: assert property ($stable(cpu_installed_n_i) [*4] |->
    cpu_present_n_oe_o == (cpu_installed_n_i != 4'hF)) else $error("present drive wrong");
  chk_any_pod: assert property (($stable(cpu_pod_good_i) && $stable(cpu_installed_n_i))
    [*4] |-> any_pod_good_out_o == |(cpu_pod_good_i & ~cpu_installed_n_i))
    else $error("any pod good wrong");
  chk_pods_after_rails: assert property (pod_enable_o != 4'h0 |-> rail_enables_o.rail_1v2
    && rail_enables_o.rail_1v5 && rail_enables_o.rail_3v3) else $error("pod enabled early");
  chk_2v5_absent: assert property ((conv_2v5_primary_present_n_i ||
    conv_2v5_secondary_present_n_i) [*4] |-> !rail_enables_o.rail_2v5)
    else $error("2.5 V enabled with converter absent");
  chk_ok_all_rails: assert property (board_power_ok_o |-> &rail_enables_o)
    else $error("power ok with a rail disabled");
  chk_pg_hold: assert property (!system_power_ok_i [*4] |-> resets_o.power_good_reset)
    else $error("power-good reset missing while power low");
  chk_pg_release: assert property (ok_cnt > 7'h32 |-> !resets_o.power_good_reset)
    else $error("power-good reset not released");
  chk_hard_reset: assert property (!system_reset_request_n_i [*4] |-> resets_o.hard_reset)
    else $error("hard reset missing");
endmodule // board_power_good_reset_control_props

bind board_power_good_reset_control board_power_good_reset_control_props u_props (.clk_i,
  .rst_i, .cyc_i, .stb_i, .ack_o, .system_power_ok_i, .system_reset_request_n_i,
  .conv_2v5_primary_present_n_i, .conv_2v5_secondary_present_n_i, .cpu_installed_n_i,
  .cpu_pod_good_i, .rail_enables_o,
  .pod_enable_o, .board_clocks_enable_o, .board_power_ok_o, .any_pod_good_out_o,
  .cpu_present_n_oe_o, .resets_o);
`default_nettype wire

// [rail_model.sv]
// Behavioural model of the regulators, converters and pods behind the enables.
`timescale 1ns/100ps
`default_nettype none
module rail_model (
  input wire logic clk_i,
  input wire logic slow_i,
  input wire pwr_reset_pkg::rail_enables_t en_i,
  input wire logic [3:0] pod_en_i,
  output logic [9:0] good_o
);
  logic [9:0] hist [0:7];
  always_ff @(posedge clk_i) begin
    hist[0] <= {en_i, pod_en_i};
    for (int i = 1; i < 8; i++) begin
      hist[i] <= hist[i-1] & {en_i, pod_en_i};
    end
  end
  // A rail is good only while still enabled, so a withdrawn enable drops it at once.
  // Bit 4 stands for both 2.5 V converters reporting valid together.
  assign good_o = (slow_i ? hist[7] : hist[1]) & {en_i, pod_en_i};
endmodule // rail_model
`default_nettype wire

// [tb_board_power_good_reset_control.sv]
// Self-checking bench for the board power-good and reset control block.
`timescale 1ns/100ps
`default_nettype none
module tb_board_power_good_reset_control;
  logic clk_i = 1'b0, rst_i = 1'b1, we_i = 1'b0, cyc_i = 1'b0, stb_i = 1'b0, ack_o;
  logic [3:0] adr_i = 4'h0, sel_i = 4'hF, legacy_irq_i = 4'h0, legacy_irq_o, pod_enable_o;
  logic [31:0] dat_i = 32'h0, dat_o, q;
  logic system_power_ok_i = 1'b0, io_side_3v3_request_i = 1'b0, pod_output_request_i = 1'b0;
  logic system_reset_request_n_i = 1'b1, bus_error_restart_n_i = 1'b1, io_event_restart_i = 1'b0;
  logic test_reset_jumper_n_i = 1'b1, mem_primary_present_n_i = 1'b1;
  logic mem_secondary_present_n_i = 1'b1, conv_3v3_present_n_i = 1'b1;
  logic conv_2v5_primary_present_n_i = 1'b1, conv_2v5_secondary_present_n_i = 1'b1;
  logic [3:0] cpu_installed_n_i = 4'hF;
  logic [9:0] good;
  logic slow = 1'b0, clr = 1'b0;
  logic [5:0] seen;
  logic [11:0] tbl [0:5] = '{12'h708, 12'h504, 12'h441, 12'h441, 12'h482, 12'h410};
  pwr_reset_pkg::rail_enables_t rail_enables_o;
  pwr_reset_pkg::reset_outs_t resets_o;
  logic board_clocks_enable_o, board_power_ok_o, any_pod_good_out_o, cpu_present_n_o;
  logic cpu_present_n_oe_o, scalability_port_enable_o, test_reset_n_o;
  wire logic rail_3v3_good_i = good[9], rail_1v5_good_i = good[8], rail_1v2_good_i = good[7];
  wire logic rail_1v8_good_i = good[6], rail_1v3_good_i = good[5];
  wire logic rail_2v5_primary_good_i = good[4], rail_2v5_secondary_good_i = good[4];
  wire logic mem_primary_1v25_good_i = good[9], mem_secondary_1v25_good_i = good[9];
  wire logic [3:0] cpu_pod_good_i = good[3:0];
  int fails = 0, n_compared = 0, cycles = 0;

  board_power_good_reset_control DUT (.*);
  rail_model u_rails (.clk_i, .slow_i(slow), .en_i(rail_enables_o), .pod_en_i(pod_enable_o),
    .good_o(good));

  always #12.5 clk_i = ~clk_i;
  always @(posedge clk_i) seen <= clr ? 6'h00 : (seen | resets_o);
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      wrap_up();
    end
  end
  // ----------------------------------------------------------------
  // Bus and compare tasks
  // ----------------------------------------------------------------
  task automatic wrap_up();
    if (fails == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1);
    q = dat_o;
    // The request is taken on the first edge and answered on the next one.
    chk(32'(n), 32'h0000_0002);
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask
  task automatic wt_ok(input logic v);
    for (int n = 0; n < 400 && board_power_ok_o !== v; n++) @(posedge clk_i);
    chk(board_power_ok_o, v);
  endtask
  // Bus commands are pulses, so a sticky capture of the reset outputs is compared.
  task automatic rc(input int k);
    clr <= 1'b1;
    @(posedge clk_i);
    clr <= 1'b0;
    case (k)
      0: wb(1'b1, pwr_reset_pkg::ctrl_addr, 32'h0000_0107);
      1: wb(1'b1, pwr_reset_pkg::ctrl_addr, 32'h0000_0108);
      2: wb(1'b1, pwr_reset_pkg::ctrl_addr, 32'h0000_0110);
      3: io_event_restart_i <= 1'b1;
      4: bus_error_restart_n_i <= 1'b0;
      default: system_reset_request_n_i <= 1'b0;
    endcase
    repeat (6) @(posedge clk_i);
    io_event_restart_i <= 1'b0;
    bus_error_restart_n_i <= 1'b1;
    system_reset_request_n_i <= 1'b1;
    repeat (8) @(posedge clk_i);
    chk(seen & tbl[k][11:6], tbl[k][5:0]);
  endtask
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, pwr_reset_pkg::ctrl_addr, 32'h0);
    chk(q, pwr_reset_pkg::ctrl_reset_value);
    wb(1'b0, 4'hC, 32'h0);
    chk(q, 32'h0);
    {mem_primary_present_n_i, conv_3v3_present_n_i} <= 2'b00;
    {conv_2v5_primary_present_n_i, conv_2v5_secondary_present_n_i} <= 2'b00;
    {io_side_3v3_request_i, pod_output_request_i, cpu_installed_n_i} <= 6'h3C;
    repeat (12) @(posedge clk_i);
    chk(rail_enables_o.rail_3v3, 1'b0);
    mem_secondary_present_n_i <= 1'b0;
    wt_ok(1'b1);
    chk(rail_enables_o, 6'h3F);
    chk(pod_enable_o, 4'h3);
    chk(board_clocks_enable_o, 1'b1);
    chk(any_pod_good_out_o, 1'b1);
    chk({cpu_present_n_oe_o, cpu_present_n_o}, 2'b10);
    system_power_ok_i <= 1'b1;
    repeat (10) @(posedge clk_i);
    chk({resets_o.power_good_reset, test_reset_n_o}, 2'b10);
    repeat (50) @(posedge clk_i);
    chk({resets_o.power_good_reset, test_reset_n_o}, 2'b01);
    for (int k = 0; k < 6; k++) rc(k);
    wb(1'b0, pwr_reset_pkg::ctrl_addr, 32'h0);
    chk(q, 32'h0000_0100);
    wb(1'b1, pwr_reset_pkg::ctrl_addr, 32'h0);
    repeat (4) @(posedge clk_i);
    chk(scalability_port_enable_o, 1'b0);
    wb(1'b1, pwr_reset_pkg::ctrl_addr, 32'h0000_0100);
    repeat (4) @(posedge clk_i);
    chk(scalability_port_enable_o, 1'b1);
    legacy_irq_i <= 4'h5;
    repeat (5) @(posedge clk_i);
    chk(legacy_irq_o, 4'h5);
    io_side_3v3_request_i <= 1'b0;
    wt_ok(1'b0);
    // Without the request the 3.3 V enable may not stand, so it falls with power ok.
    chk(rail_enables_o.rail_3v3, 1'b0);
    repeat (20) @(posedge clk_i);
    chk({rail_enables_o, pod_enable_o}, 10'h000);
    slow <= 1'b1;
    conv_2v5_secondary_present_n_i <= 1'b1;
    io_side_3v3_request_i <= 1'b1;
    repeat (80) @(posedge clk_i);
    chk({rail_enables_o.rail_2v5, board_power_ok_o}, 2'b00);
    conv_2v5_secondary_present_n_i <= 1'b0;
    wt_ok(1'b1);
    wrap_up();
  end
endmodule // tb_board_power_good_reset_control
`default_nettype wire
